/* hw/rtc_evt_pkg.sv */
// Shared constants and carriers for the clock event status block.
// Assumes a 25 MHz system clock and a 32-bit APB register port.
package rtc_evt_pkg;

  // ----------------------------------------------------------------
  // Register map (printed offsets are indexes; byte address = 4*idx)
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDX_CONTROL_B   = 8'h0b;
  localparam logic [7:0]  IDX_STATUS      = 8'h0c;
  localparam logic [7:0]  IDX_DATE_ALARM  = 8'h0d;
  localparam logic [11:0] ADDR_CONTROL_B  = {2'h0, IDX_CONTROL_B, 2'h0};
  localparam logic [11:0] ADDR_STATUS     = {2'h0, IDX_STATUS, 2'h0};
  localparam logic [11:0] ADDR_DATE_ALARM = {2'h0, IDX_DATE_ALARM, 2'h0};

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         BIT_SUMMARY     = 7;
  localparam int         BIT_PERIODIC    = 6;
  localparam int         BIT_ALARM       = 5;
  localparam int         BIT_UPDATE      = 4;
  localparam int         BIT_INHIBIT     = 7;
  localparam int         DATE_W          = 6;
  localparam logic [7:0] CONTROL_B_RESET = 8'h00;
  localparam logic [5:0] DATE_RESET      = 6'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ        = 25000000;
  localparam int SECOND_MS       = 1000;
  localparam int SECOND_CYCLES   = CLOCK_HZ / 1000 * SECOND_MS;
  localparam int STABLE_MS       = 999;
  localparam int STABLE_CYCLES   = CLOCK_HZ / 1000 * STABLE_MS;

  // Event inputs grouped together
  typedef struct packed {
    logic periodic;
    logic alarm_hit;
  } evt_in_s;

endpackage : rtc_evt_pkg

/* hw/rtc_evt_status.sv */
// Event status flags, summary request and date-alarm qualifier.
// Assumes event inputs are one-cycle pulses synchronous to clock.
// Overview of operation
// - Summary bit set when enabled flag set
// - Periodic tick sets sticky flag bit 6
// - Alarm match sets sticky flag bit 5
// - Update end sets sticky flag bit 4
// - Time registers frozen SECOND_CYCLES-1 cycles after update
// - Status read clears flags; events survive
// - Nonzero date field must equal month
// - Control bits 6..4 enable summary
// - Updates once per second unless inhibited
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
module rtc_evt_status #(
  parameter int SECOND_CYCLES = rtc_evt_pkg::SECOND_CYCLES
) (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire rtc_evt_pkg::evt_in_s evt_in,
  input  wire logic [7:0]           month,
  output logic                      update_done,
  output logic                      time_stable,
  output logic                      irq
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic       access;
  logic       wr_en;
  logic       rd_status;
  logic [7:0] control_b_r;
  logic [5:0] date_r;
  logic [2:0] flags_r;
  logic       alarm_ok;
  logic       summary;
  logic       inhibit;
  logic [31:0] stable_r;

  // Zero wait states keep the read-clear to exactly one edge
  assign access    = psel && penable;
  assign wr_en     = access && pwrite;
  assign rd_status = access && !pwrite && (paddr == rtc_evt_pkg::ADDR_STATUS);
  assign pready    = 1'b1;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == rtc_evt_pkg::ADDR_CONTROL_B) || (a == rtc_evt_pkg::ADDR_STATUS)
          || (a == rtc_evt_pkg::ADDR_DATE_ALARM);
  endfunction : mapped

  assign pslverr = access && !mapped(paddr);

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  // Control register: inhibit and three enables; bits 3:0 stored too, bit 3 reads back as zero
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      control_b_r <= rtc_evt_pkg::CONTROL_B_RESET;
    else if (wr_en && paddr == rtc_evt_pkg::ADDR_CONTROL_B)
      control_b_r <= pwdata[7:0];
  end

  // Date alarm field; upper bits reserved, read zero
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      date_r <= rtc_evt_pkg::DATE_RESET;
    else if (wr_en && paddr == rtc_evt_pkg::ADDR_DATE_ALARM)
      date_r <= pwdata[5:0];
  end

  // ----------------------------------------------------------------
  // Update pacing
  // ----------------------------------------------------------------
  assign inhibit = control_b_r[rtc_evt_pkg::BIT_INHIBIT];

  update_pacer #(
    .PERIOD (SECOND_CYCLES)
  ) u_pacer (
    .clock       (clock),
    .rst_n       (rst_n),
    .inhibit     (inhibit),
    .update_done (update_done)
  );

  // stable window count
  // Time/date owner must not change registers while this is high
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      stable_r <= 32'h0;
    else if (update_done)
      stable_r <= 32'(SECOND_CYCLES - 1);
    else if (stable_r != 32'h0)
      stable_r <= stable_r - 32'h1;
  end

  assign time_stable = (stable_r != 32'h0);

  // ----------------------------------------------------------------
  // Alarm qualification and flags
  // ----------------------------------------------------------------
  // month must match unless the date field is zero
  assign alarm_ok = (date_r == 6'h00) || ({2'h0, date_r} == month);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      flags_r <= 3'h0;
    else
      flags_r <= (rd_status ? 3'h0 : flags_r)
               | {evt_in.periodic, evt_in.alarm_hit && alarm_ok, update_done};
  end

  assign summary = |(flags_r & control_b_r[rtc_evt_pkg::BIT_PERIODIC:rtc_evt_pkg::BIT_UPDATE]);

  assign irq = summary;

  // Read data mux
  always_comb
  begin
    prdata = 32'h0;
    if (access && !pwrite)
    begin
      unique case (paddr)
        rtc_evt_pkg::ADDR_CONTROL_B:  prdata = {24'h0, control_b_r[7:4], 1'b0, control_b_r[2:0]};
        rtc_evt_pkg::ADDR_STATUS:     prdata = {24'h0, summary, flags_r, 4'h0};
        rtc_evt_pkg::ADDR_DATE_ALARM: prdata = {26'h0, date_r};
        default:                      prdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_status_read;
    rd_status;
  endsequence

  property p_summary;
    @(posedge clock) disable iff (!rst_n)
    summary == |(flags_r & control_b_r[6:4]);
  endproperty
  a_summary: assert property (p_summary) else $error("summary mismatch");

  property p_periodic;
    @(posedge clock) disable iff (!rst_n)
    evt_in.periodic |=> flags_r[2];
  endproperty
  a_periodic: assert property (p_periodic) else $error("periodic lost");

  property p_alarm;
    @(posedge clock) disable iff (!rst_n)
    (evt_in.alarm_hit && alarm_ok) |=> flags_r[1];
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm lost");

  property p_update;
    @(posedge clock) disable iff (!rst_n)
    update_done |=> flags_r[0] && time_stable;
  endproperty
  a_update: assert property (p_update) else $error("update flag lost");

  property p_clear;
    @(posedge clock) disable iff (!rst_n)
    s_status_read and !evt_in.periodic and !evt_in.alarm_hit and !update_done
      |=> flags_r == 3'h0 && !irq;
  endproperty
  a_clear: assert property (p_clear) else $error("read did not clear");

  property p_date;
    @(posedge clock) disable iff (!rst_n)
    (date_r != 6'h00 && {2'h0, date_r} != month && !rd_status && !flags_r[1])
      |=> !flags_r[1];
  endproperty
  a_date: assert property (p_date) else $error("alarm not suppressed");

  property p_inhibit;
    @(posedge clock) disable iff (!rst_n)
    inhibit |-> !update_done;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("update while inhibited");

  property p_irq;
    @(posedge clock) disable iff (!rst_n)
    $rose(flags_r[2]) && control_b_r[6] |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");

  // Zero date field lets every alarm through
  property p_nodate;
    @(posedge clock) disable iff (!rst_n)
    (date_r == 6'h00 && evt_in.alarm_hit) |=> flags_r[1];
  endproperty
  a_nodate: assert property (p_nodate) else $error("alarm dropped with open date");

  // No update may land while the stable window is still open
  property p_stable;
    @(posedge clock) disable iff (!rst_n)
    time_stable |-> !update_done;
  endproperty
  a_stable: assert property (p_stable) else $error("update inside stable window");

  // With every enable clear no flag may reach the request line
  property p_mask;
    @(posedge clock) disable iff (!rst_n)
    (control_b_r[6:4] == 3'h0) |-> !irq;
  endproperty
  a_mask: assert property (p_mask) else $error("masked flag raised irq");

endmodule : rtc_evt_status

/* hw/update_pacer.sv */
// One-second update pacer: pulses update_done once per period.
// Assumes the pulse is the end of the time/date update step.
`timescale 1ns/10ps
module update_pacer #(
  parameter int PERIOD = rtc_evt_pkg::SECOND_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic inhibit,
  output logic      update_done
);

  logic [31:0] count_r;

  // Count held at zero while updates are inhibited
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      count_r <= 32'h0;
    else if (inhibit)
      count_r <= 32'h0;
    else if (count_r == 32'(PERIOD - 1))
      count_r <= 32'h0;
    else
      count_r <= count_r + 32'h1;
  end

  assign update_done = !inhibit && (count_r == 32'(PERIOD - 1));

endmodule : update_pacer

/* test/tb.sv */
// Bench for the event status block: APB access, events, date match.
// Assumes rtc_evt_pkg and rtc_evt_status are compiled before it.
`timescale 1ns/10ps
module tb;
  logic                 clock, rst_n, psel, penable, pwrite, pready, pslverr;
  logic                 update_done, time_stable, irq, er;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, rd;
  logic [7:0]           month;
  logic [2:0]           en;
  logic [1:0]           ev;
  rtc_evt_pkg::evt_in_s evt_in;
  logic [5:0]           dt [3] = '{6'h05, 6'h03, 6'h05};
  int                   err_total = 0, cmp_count = 0, cyc = 0;

  // Short count so one update period fits in a few transfers
  rtc_evt_status #(.SECOND_CYCLES(50)) uut (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .evt_in(evt_in), .month(month),
    .update_done(update_done), .time_stable(time_stable), .irq(irq));

  // ----------------------------------------------------------------
  // Clock, timeout and checking helpers
  // ----------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Cuts a hang short; the run needs well under 3000 cycles
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total = err_total + 1;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Expected status byte from flags {periodic, alarm, update} and enables
  function automatic logic [31:0] st(input logic [2:0] f, input logic [2:0] e);
    return {24'h0, |(f & e), f, 4'h0};
  endfunction : st

  // One APB transfer; e pulses events in the access cycle itself
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] e);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    evt_in <= e;
    @(posedge clock);
    evt_in <= 2'b00;
    while (pready !== 1'b1)
      @(posedge clock);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 2'b00);
    chk(rd, exp);
  endtask : rdc

  task automatic pulse(input logic [1:0] e);
    @(posedge clock);
    evt_in <= e;
    @(posedge clock);
    evt_in <= 2'b00;
  endtask : pulse

  task automatic finish_test();
    $display("Compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    evt_in = 2'b00;
    month = 8'h05;
    void'($urandom(32'h3a1b));
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    rdc(rtc_evt_pkg::ADDR_CONTROL_B, 32'h0);
    rdc(rtc_evt_pkg::ADDR_DATE_ALARM, 32'h0);
    rdc(rtc_evt_pkg::ADDR_STATUS, 32'h0);
    rdc(12'h040, 32'h0);
    chk({31'h0, er}, 32'h1);
    // Random enables and events with updates held off
    for (int i = 0; i < 24; i++)
    begin
      en = 3'($urandom);
      ev = 2'($urandom);
      apb(1'b1, rtc_evt_pkg::ADDR_CONTROL_B, {24'h0, 1'b1, en, 4'h0}, 2'b00);
      pulse(ev);
      @(negedge clock);
      chk({31'h0, irq}, {31'h0, |(ev & en[2:1])});
      rdc(rtc_evt_pkg::ADDR_STATUS, st({ev, 1'b0}, en));
      // The clear lands at the access edge; look once it has settled
      @(negedge clock);
      chk({31'h0, irq}, 32'h0);
    end
    apb(1'b1, rtc_evt_pkg::ADDR_CONTROL_B, 32'hf0, 2'b00);
    // Date field against month, upper bits of the month included
    for (int i = 0; i < 3; i++)
    begin
      month <= (i == 2) ? 8'h45 : 8'h05;
      apb(1'b1, rtc_evt_pkg::ADDR_DATE_ALARM, {26'h3ffffff, dt[i]}, 2'b00);
      rdc(rtc_evt_pkg::ADDR_DATE_ALARM, {26'h0, dt[i]});
      pulse(2'b01);
      rdc(rtc_evt_pkg::ADDR_STATUS, st({1'b0, i == 0, 1'b0}, 3'b111));
    end
    // Event in the read cycle itself must survive the clear
    apb(1'b0, rtc_evt_pkg::ADDR_STATUS, 32'h0, 2'b10);
    chk(rd, 32'h0);
    rdc(rtc_evt_pkg::ADDR_STATUS, 32'hc0);
    // Updates run once inhibit drops, and stop when it is set
    apb(1'b1, rtc_evt_pkg::ADDR_CONTROL_B, 32'h70, 2'b00);
    for (int k = 0; k < 60 && update_done !== 1'b1; k++)
      @(negedge clock);
    chk({31'h0, update_done}, 32'h1);
    rdc(rtc_evt_pkg::ADDR_STATUS, 32'h90);
    chk({31'h0, time_stable}, 32'h1);
    apb(1'b1, rtc_evt_pkg::ADDR_CONTROL_B, 32'hf0, 2'b00);
    rdc(rtc_evt_pkg::ADDR_STATUS, 32'h0);
    repeat (60) @(posedge clock);
    chk({31'h0, time_stable}, 32'h0);
    rdc(rtc_evt_pkg::ADDR_STATUS, 32'h0);
    finish_test();
  end
endmodule : tb
